// [hw/irs_defines.svh]
/*
 * Register offsets, reset values, bit positions and vectors of the
 * interrupt and reset-status block.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef IRS_DEFINES_SVH
`define IRS_DEFINES_SVH

// Register space (data side)
`define IRS_OFF_STATUS 8'h03
`define IRS_OFF_FLAGS 8'h0f
`define IRS_OFF_RAM_LO 8'h10
`define IRS_OFF_RAM_HI 8'h2f
// Control space
`define IRS_OFF_IOC_A 8'h0a
`define IRS_OFF_PULL_DN 8'h0b
`define IRS_OFF_OPEN_DR 8'h0c
`define IRS_OFF_PULL_HI 8'h0d
`define IRS_OFF_WDT_EDGE 8'h0e
`define IRS_OFF_MASK 8'h0f

// Reset values
`define IRS_RST_IOC_A 8'hff
`define IRS_RST_PULL_DN 8'hff
`define IRS_RST_OPEN_DR 8'h00
`define IRS_RST_PULL_HI 8'hff
`define IRS_RST_IRQ3 3'h0

// Bit positions
`define IRS_BIT_TMR 0
`define IRS_BIT_CHG 1
`define IRS_BIT_EXT 2
`define IRS_BIT_WATCHDOG_ENABLE_BIT 7
`define IRS_BIT_EIS 6
`define IRS_BIT_ROC 4
`define IRS_BIT_TO 4
`define IRS_BIT_PD 3
`define IRS_BIT_PIN0 0

// Vectors
`define IRS_VEC_HW 11'h008
`define IRS_VEC_SW 11'h001

// Widths
`define IRS_RAM_WORDS 32
`define IRS_NIRQ 3

`endif

// [hw/irs_pkg.sv]
/*
 * Types shared by the interrupt and reset-status block.
 * Assumes irs_defines.svh is on the include path.
 */
package irs_pkg;
  `include "irs_defines.svh"

  // Run/sleep sequencing, one-hot
  typedef enum logic [1:0] {
    IRS_RUN = 2'b01,
    IRS_SLEEP = 2'b10
  } irs_state_e;

  // Register port request from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic ctrl;
    logic [7:0] addr;
    logic [7:0] wdata;
  } irs_bus_s;

  // Decoded instruction pulses from the core
  typedef struct packed {
    logic enable_interrupts_instr;
    logic disable_interrupts_instr;
    logic return_from_interrupt_instr;
    logic sleep;
    logic watchdog_clear_instr;
    logic swint;
  } irs_instr_s;

  // Vector request to the sequencer
  typedef struct packed {
    logic valid;
    logic [10:0] addr;
  } irs_vec_s;
endpackage : irs_pkg

// [hw/irs_top.sv]
/*
 * Interrupt flags, masks, global enable, vectoring, sleep/wake and
 * time-out/power-down status of a small 8-bit controller.
 * Assumes the core gives one-cycle instruction pulses, an instruction
 * boundary strobe, and all inputs synchronous to I_REF_CLK.
 */
`timescale 1ns/1ps
`include "irs_defines.svh"

// What this block does
// R1: Three sources: timer overflow, port change, falling edge on external pin.
// R2: Flag register at 0x0F, bits 0..2, cleared by resets, kept on wake.
// R3: Mask register in control space 0x0F, cleared by resets, kept on wake.
// R4: Timer and external flags set always; port-change flag only when enabled.
// R5: Flag register reads as flags AND masks.
// R6: Enable instruction sets global enable; disable instruction clears it.
// R7: Enabled unmasked interrupt with global enable vectors to 008H.
// R8: Return-from-interrupt sets global enable like the enable instruction.
// R9: Software interrupt instruction, when enabled, vectors to 001H.
// R10: Input pins raise port change; outputs and active external pin excluded.
// R11: Software reads the port before enabling port-change interrupt.
// R12: Enabled port change wakes from sleep; resume next or vector 008H.
// R13: Service routine clears its flag before returning or re-enabling.
// R14: Reset on power-on, reset-pin high-low-high pulse, or watchdog time-out.
// R15: Reset-cause time-out and power-down flags follow the reset kind.
// R16: Watchdog clear sets both; sleep sets 1,0; time-out clears time-out.
// R17: Control 0x0E resets bit7 to 1, bits 6,4 to 0; wake forces bit7.
// R18: Sleep instruction enters power-down; running watchdog cleared, keeps counting.
// R19: Software enables only one wake source before sleeping.
// R20: Sample at instruction boundaries; clear global enable when vectoring.
module irs_top (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire irs_pkg::irs_bus_s I_BUS,
  output logic [7:0] O_RDATA,
  input wire irs_pkg::irs_instr_s I_INSTR,
  input wire logic I_BOUNDARY,
  input wire logic I_TMR_OVF,
  input wire logic [7:0] I_PORT,
  input wire logic I_PORT_RD,
  input wire logic I_RESET_PIN_N,
  input wire logic I_WDT_TIMEOUT,
  output irs_pkg::irs_vec_s O_VECTOR,
  output logic O_WAKE,
  output logic O_SLEEPING,
  output logic O_CORE_RST,
  output logic O_GIE,
  output logic O_TO,
  output logic O_PD,
  output logic O_WDT_EN,
  output logic O_WDT_CLR,
  output logic [7:0] O_IOC_A,
  output logic [7:0] O_PULL_DN,
  output logic [7:0] O_OPEN_DR,
  output logic [7:0] O_PULL_HI,
  output logic O_EXT_SEL,
  output logic O_ROPT
);
  import irs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Match one offset in one space for a strobe
  function automatic logic hit(input logic stb, input logic ctl, input logic [7:0] off);
    hit = stb && (I_BUS.ctrl == ctl) && (I_BUS.addr == off);
  endfunction : hit

  irs_state_e state_r;
  logic pin_n_r, warm_pin, warm_rst, gie_r, to_r, pd_r, watchdog_enable_bit_r, eis_r, roc_r, ext_pin_r;
  logic port_chg, ext_fall, wake, take_hw, take_sw, ram_rd, ram_wr;
  logic [2:0] flag_r, mask_r, flag_set;
  logic [7:0] ioc_a_r, pull_dn_r, open_dr_r, pull_hi_r, port_ref_r, in_pins, rdata_nxt;
  logic [4:0] ram_idx;
  logic [7:0] ram [`IRS_RAM_WORDS];

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources
  // Pin reset fires on the return high, so a held-low pin keeps the core parked
  assign warm_pin = I_RESET_PIN_N && !pin_n_r; // R14
  assign warm_rst = warm_pin || I_WDT_TIMEOUT; // R14

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_n_r <= 1'b1;
    end else begin
      pin_n_r <= I_RESET_PIN_N;
    end
  end

  // Core held in reset while the pin is low and for the firing cycle
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CORE_RST <= 1'b1;
    end else begin
      O_CORE_RST <= !I_RESET_PIN_N || warm_rst; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection
  // External pin takes bit 0 away from change detection while selected
  assign in_pins = ioc_a_r & ~({7'h00, eis_r}); // R10
  assign port_chg = |((I_PORT ^ port_ref_r) & in_pins); // R10
  assign ext_fall = eis_r && ext_pin_r && !I_PORT[`IRS_BIT_PIN0]; // R1
  assign flag_set[`IRS_BIT_TMR] = I_TMR_OVF; // R4
  assign flag_set[`IRS_BIT_CHG] = port_chg && mask_r[`IRS_BIT_CHG]; // R4
  assign flag_set[`IRS_BIT_EXT] = ext_fall; // R4
  assign wake = (state_r == IRS_SLEEP) && flag_set[`IRS_BIT_CHG]; // R12

  // Reference levels only move on a port read, so software must read first
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      port_ref_r <= 8'h00;
      ext_pin_r <= 1'b1;
    end else begin
      ext_pin_r <= I_PORT[`IRS_BIT_PIN0];
      if (I_PORT_RD) begin
        port_ref_r <= I_PORT; // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and masks
  // A new event wins over a software clear in the same cycle
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_r <= `IRS_RST_IRQ3; // R2
    end else if (warm_rst) begin
      flag_r <= `IRS_RST_IRQ3; // R2
    end else if (hit(I_BUS.wr, 1'b0, `IRS_OFF_FLAGS)) begin
      flag_r <= I_BUS.wdata[2:0] | flag_set; // R13
    end else begin
      flag_r <= flag_r | flag_set; // R4
    end
  end
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      mask_r <= `IRS_RST_IRQ3; // R3
    end else if (warm_rst) begin
      mask_r <= `IRS_RST_IRQ3; // R3
    end else if (hit(I_BUS.wr, 1'b1, `IRS_OFF_MASK)) begin
      mask_r <= I_BUS.wdata[2:0]; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global enable and vectoring
  // Pending flags are taken only at a boundary; software and wake vectors need no boundary
  assign take_hw = (state_r == IRS_RUN) && I_BOUNDARY && gie_r && |(flag_r & mask_r); // R7 R20
  assign take_sw = (state_r == IRS_RUN) && I_INSTR.swint && gie_r && !take_hw; // R9

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      gie_r <= 1'b0;
    end else if (warm_rst) begin
      gie_r <= 1'b0;
    end else if (take_hw || take_sw || (wake && gie_r)) begin
      gie_r <= 1'b0; // R20
    end else if (I_INSTR.enable_interrupts_instr || I_INSTR.return_from_interrupt_instr) begin
      gie_r <= 1'b1; // R6 R8
    end else if (I_INSTR.disable_interrupts_instr) begin
      gie_r <= 1'b0; // R6
    end
  end

  // Vector pulse: hardware 008H beats software 001H
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_VECTOR <= '0;
    end else if ((take_hw || (wake && gie_r)) && !warm_rst) begin
      O_VECTOR <= '{valid: 1'b1, addr: `IRS_VEC_HW}; // R7 R12
    end else if (take_sw && !warm_rst) begin
      O_VECTOR <= '{valid: 1'b1, addr: `IRS_VEC_SW}; // R9
    end else begin
      O_VECTOR <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencing
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_r <= IRS_RUN;
    end else if (warm_rst) begin
      state_r <= IRS_RUN; // R14
    end else begin
      unique case (state_r)
        IRS_RUN: begin
          if (I_INSTR.sleep) begin
            state_r <= IRS_SLEEP; // R18
          end
        end
        IRS_SLEEP: begin
          if (wake) begin
            state_r <= IRS_RUN; // R12
          end
        end
        default: begin
          state_r <= IRS_RUN;
        end
      endcase
    end
  end

  // Wake pulse tells the core to resume; with enable set a vector rides along
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WAKE <= 1'b0;
    end else begin
      O_WAKE <= wake && !warm_rst; // R12
    end
  end
  // Watchdog counter lives outside; clearing it does not stop it
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WDT_CLR <= 1'b0;
    end else begin
      O_WDT_CLR <= (state_r == IRS_RUN) && (I_INSTR.watchdog_clear_instr || I_INSTR.sleep); // R16 R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-out and power-down status
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      to_r <= 1'b1; // R15
      pd_r <= 1'b1; // R15
    end else if (I_WDT_TIMEOUT) begin
      to_r <= 1'b0; // R15 R16
      if (state_r == IRS_SLEEP) begin
        pd_r <= 1'b0; // R15
      end
    end else if (warm_pin) begin
      if (state_r == IRS_SLEEP) begin
        to_r <= 1'b1; // R15
        pd_r <= 1'b0; // R15
      end
    end else if (wake) begin
      to_r <= 1'b1; // R15
      pd_r <= 1'b0; // R15
    end else if ((state_r == IRS_RUN) && I_INSTR.watchdog_clear_instr) begin
      to_r <= 1'b1; // R16
      pd_r <= 1'b1; // R16
    end else if ((state_r == IRS_RUN) && I_INSTR.sleep) begin
      to_r <= 1'b1; // R16
      pd_r <= 1'b0; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control-space registers
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      watchdog_enable_bit_r <= 1'b1; // R17
      eis_r <= 1'b0;
      roc_r <= 1'b0;
    end else if (warm_rst) begin
      watchdog_enable_bit_r <= 1'b1; // R17
      eis_r <= 1'b0;
      roc_r <= 1'b0;
    end else if (wake) begin
      watchdog_enable_bit_r <= 1'b1; // R17
    end else if (hit(I_BUS.wr, 1'b1, `IRS_OFF_WDT_EDGE)) begin
      watchdog_enable_bit_r <= I_BUS.wdata[`IRS_BIT_WATCHDOG_ENABLE_BIT];
      eis_r <= I_BUS.wdata[`IRS_BIT_EIS];
      roc_r <= I_BUS.wdata[`IRS_BIT_ROC];
    end
  end
  // Pad controls: kept across wake, restored by any reset
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ioc_a_r <= `IRS_RST_IOC_A;
      pull_dn_r <= `IRS_RST_PULL_DN;
      open_dr_r <= `IRS_RST_OPEN_DR;
      pull_hi_r <= `IRS_RST_PULL_HI;
    end else if (warm_rst) begin
      ioc_a_r <= `IRS_RST_IOC_A;
      pull_dn_r <= `IRS_RST_PULL_DN;
      open_dr_r <= `IRS_RST_OPEN_DR;
      pull_hi_r <= `IRS_RST_PULL_HI;
    end else begin
      if (hit(I_BUS.wr, 1'b1, `IRS_OFF_IOC_A)) begin
        ioc_a_r <= I_BUS.wdata;
      end
      if (hit(I_BUS.wr, 1'b1, `IRS_OFF_PULL_DN)) begin
        pull_dn_r <= I_BUS.wdata;
      end
      if (hit(I_BUS.wr, 1'b1, `IRS_OFF_OPEN_DR)) begin
        open_dr_r <= I_BUS.wdata;
      end
      if (hit(I_BUS.wr, 1'b1, `IRS_OFF_PULL_HI)) begin
        pull_hi_r <= I_BUS.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General-purpose RAM, no reset: contents survive every reset kind
  assign ram_idx = I_BUS.addr[4:0];
  assign ram_wr = I_BUS.wr && !I_BUS.ctrl && (I_BUS.addr >= `IRS_OFF_RAM_LO) && (I_BUS.addr <= `IRS_OFF_RAM_HI);
  assign ram_rd = I_BUS.rd && !I_BUS.ctrl && (I_BUS.addr >= `IRS_OFF_RAM_LO) && (I_BUS.addr <= `IRS_OFF_RAM_HI);
  always_ff @(posedge I_REF_CLK) begin
    if (ram_wr) begin
      ram[ram_idx] <= I_BUS.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data stand for one cycle, zero otherwise or when unmapped
  always_comb begin
    rdata_nxt = 8'h00;
    if (ram_rd) begin
      rdata_nxt = ram[ram_idx];
    end else if (hit(I_BUS.rd, 1'b0, `IRS_OFF_FLAGS)) begin
      rdata_nxt = {5'h00, flag_r & mask_r}; // R5
    end else if (hit(I_BUS.rd, 1'b0, `IRS_OFF_STATUS)) begin
      rdata_nxt[`IRS_BIT_TO] = to_r;
      rdata_nxt[`IRS_BIT_PD] = pd_r;
    end else if (hit(I_BUS.rd, 1'b1, `IRS_OFF_MASK)) begin
      rdata_nxt = {5'h00, mask_r};
    end else if (hit(I_BUS.rd, 1'b1, `IRS_OFF_WDT_EDGE)) begin
      rdata_nxt[`IRS_BIT_WATCHDOG_ENABLE_BIT] = watchdog_enable_bit_r;
      rdata_nxt[`IRS_BIT_EIS] = eis_r;
      rdata_nxt[`IRS_BIT_ROC] = roc_r;
    end else if (hit(I_BUS.rd, 1'b1, `IRS_OFF_IOC_A)) begin
      rdata_nxt = ioc_a_r;
    end else if (hit(I_BUS.rd, 1'b1, `IRS_OFF_PULL_DN)) begin
      rdata_nxt = pull_dn_r;
    end else if (hit(I_BUS.rd, 1'b1, `IRS_OFF_OPEN_DR)) begin
      rdata_nxt = open_dr_r;
    end else if (hit(I_BUS.rd, 1'b1, `IRS_OFF_PULL_HI)) begin
      rdata_nxt = pull_hi_r;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= rdata_nxt;
    end
  end
  // Plain register views
  assign O_SLEEPING = (state_r == IRS_SLEEP);
  assign O_GIE = gie_r;
  assign O_TO = to_r;
  assign O_PD = pd_r;
  assign O_WDT_EN = watchdog_enable_bit_r;
  assign O_IOC_A = ioc_a_r;
  assign O_PULL_DN = pull_dn_r;
  assign O_OPEN_DR = open_dr_r;
  assign O_PULL_HI = pull_hi_r;
  assign O_EXT_SEL = eis_r;
  assign O_ROPT = roc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  a_timer_flag_set: assert property (I_TMR_OVF && !warm_rst |=> flag_r[`IRS_BIT_TMR]) // R4
    else $error("timer flag not set");
  a_change_needs_mask: assert property (!mask_r[`IRS_BIT_CHG] && !hit(I_BUS.wr, 1'b0, `IRS_OFF_FLAGS)
    && !flag_r[`IRS_BIT_CHG] |=> !flag_r[`IRS_BIT_CHG]) // R4
    else $error("port change flag set while masked");
  a_flag_read_and: assert property (hit(I_BUS.rd, 1'b0, `IRS_OFF_FLAGS) && !ram_rd
    |=> O_RDATA == {5'h00, $past(flag_r) & $past(mask_r)}) // R5
    else $error("flag read is not flags and masks");
  a_vector_hw: assert property (take_hw && !warm_rst
    |=> O_VECTOR.valid && O_VECTOR.addr == `IRS_VEC_HW && !gie_r) // R7
    else $error("hardware vector missing");
  a_vector_sw: assert property (take_sw && !warm_rst |=> O_VECTOR.valid && O_VECTOR.addr == `IRS_VEC_SW) // R9
    else $error("software vector missing");
  a_gie_eni: assert property ((I_INSTR.enable_interrupts_instr || I_INSTR.return_from_interrupt_instr) && !take_hw && !take_sw && !wake && !warm_rst
    |=> gie_r) // R6
    else $error("global enable not set");
  a_gie_disable_interrupts_instr: assert property (I_INSTR.disable_interrupts_instr && !I_INSTR.enable_interrupts_instr && !I_INSTR.return_from_interrupt_instr |=> !gie_r) // R6
    else $error("global enable not cleared");
  a_no_vec_noenable: assert property (!gie_r |=> !O_VECTOR.valid) // R20
    else $error("vector without global enable");
  a_wake_resume: assert property (wake && !gie_r && !warm_rst
    |=> O_WAKE && !O_VECTOR.valid && !O_SLEEPING ##1 !O_WAKE) // R12
    else $error("wake without enable misbehaved");
  a_sleep_status: assert property (state_r == IRS_RUN && I_INSTR.sleep && !I_INSTR.watchdog_clear_instr && !warm_rst
    |=> O_SLEEPING && to_r && !pd_r && $rose(O_WDT_CLR)) // R16
    else $error("sleep entry status wrong");
  a_wdt_timeout: assert property (I_WDT_TIMEOUT |=> !to_r && O_CORE_RST && flag_r == `IRS_RST_IRQ3) // R15
    else $error("watchdog reset status wrong");
  a_wake_watchdog_enable_bit: assert property (wake && !warm_rst |=> watchdog_enable_bit_r && to_r && !pd_r) // R17
    else $error("wake did not force watchdog enable");
  c_hw_vector: cover property (take_hw ##1 O_VECTOR.valid);
  c_sleep_wake: cover property (O_SLEEPING ##[1:50] O_WAKE);
  c_pin_reset: cover property (!I_RESET_PIN_N ##1 I_RESET_PIN_N);
  c_sw_vector: cover property (take_sw);
endmodule : irs_top

// [test/irs_core_model.sv]
/*
 * Core model: instruction boundary strobe and fetch tracking.
 * Assumes the block's vector pulse and its sleep and core-reset levels.
 */
`timescale 1ns/1ps
module irs_core_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire irs_pkg::irs_vec_s i_vector,
  input wire logic i_sleeping,
  input wire logic i_core_rst,
  output logic o_boundary,
  output logic [7:0] o_vec_cnt,
  output logic [10:0] o_fetch
);
  import irs_pkg::*;

  // Two clocks per instruction; halted core makes no boundary
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_boundary <= 1'b0;
    end else begin
      o_boundary <= !o_boundary && !i_sleeping && !i_core_rst;
    end
  end

  // Vector wins over the sequential step
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fetch <= 11'h000;
      o_vec_cnt <= 8'h00;
    end else if (i_vector.valid) begin
      o_fetch <= i_vector.addr;
      o_vec_cnt <= o_vec_cnt + 8'h01;
    end else if (o_boundary) begin
      o_fetch <= o_fetch + 11'h001;
    end
  end
endmodule : irs_core_model

// [test/irs_top_tb_top.sv]
/*
 * Self-checking bench of the interrupt and reset-status block.
 * Assumes irs_core_model supplies the boundary strobe.
 */
`timescale 1ns/1ps
module irs_top_tb_top;
  import irs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  irs_bus_s bus = '0;
  irs_instr_s ins = '0;
  logic tmr = 1'b0;
  logic [7:0] port = 8'h00;
  logic prd = 1'b0;
  logic pin_n = 1'b1;
  logic wdt = 1'b0;
  logic bnd, wake, slp, crst, gie, to, pd, wen, wclr, esel, ropt;
  logic [7:0] rdata, ioc_a, pdn, odr, phi, vcnt, d, c;
  logic [10:0] fetch;
  irs_vec_s vec;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  irs_top u_irs_top (.I_REF_CLK(clk), .I_RST(rst), .I_BUS(bus), .O_RDATA(rdata),
    .I_INSTR(ins), .I_BOUNDARY(bnd), .I_TMR_OVF(tmr), .I_PORT(port),
    .I_PORT_RD(prd), .I_RESET_PIN_N(pin_n), .I_WDT_TIMEOUT(wdt),
    .O_VECTOR(vec), .O_WAKE(wake), .O_SLEEPING(slp), .O_CORE_RST(crst),
    .O_GIE(gie), .O_TO(to), .O_PD(pd), .O_WDT_EN(wen), .O_WDT_CLR(wclr),
    .O_IOC_A(ioc_a), .O_PULL_DN(pdn), .O_OPEN_DR(odr), .O_PULL_HI(phi),
    .O_EXT_SEL(esel), .O_ROPT(ropt));

  irs_core_model u_irs_core_model (.i_clk(clk), .i_rst(rst), .i_vector(vec),
    .i_sleeping(slp), .i_core_rst(crst), .o_boundary(bnd),
    .o_vec_cnt(vcnt), .o_fetch(fetch));

  // 100 MHz reference clock
  always #5 clk = ~clk;

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Bus cycles: strobe for one cycle, read data sampled in the next
  task automatic wr(input logic ct, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{rd: 1'b0, wr: 1'b1, ctrl: ct, addr: a, wdata: v};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic ct, input logic [7:0] a);
    @(posedge clk);
    bus <= '{rd: 1'b1, wr: 1'b0, ctrl: ct, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd

  task automatic op(input irs_instr_s v);
    @(posedge clk);
    ins <= v;
    @(posedge clk);
    ins <= '0;
    #1;
  endtask : op

  task automatic pulse(input int k);
    @(posedge clk);
    if (k == 0) tmr <= 1'b1;
    else if (k == 1) wdt <= 1'b1;
    else prd <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    wdt <= 1'b0;
    prd <= 1'b0;
    #1;
  endtask : pulse

  task automatic wait_vec(input logic [7:0] c0);
    int n = 0;
    while (vcnt === c0 && n < 20) begin
      tick(1);
      n++;
    end
    chk("vector seen", {15'h0, vcnt !== c0}, 16'h1);
  endtask : wait_vec

  ////////////////////////////////////////////////////////////
  task automatic s_reset_vals();
    chk("ioc_a", ioc_a, 8'hff);
    chk("pull_dn", pdn, 8'hff);
    chk("open_dr", odr, 8'h00);
    chk("pull_hi", phi, 8'hff);
    chk("watchdog_enable_bit ext rop", {wen, esel, ropt}, 3'b100);
    chk("to pd", {to, pd}, 2'b11);
    rd(1'b0, 8'h03);
    chk("status", d & 8'h18, 8'h18);
    rd(1'b0, 8'h0f);
    chk("flags", d, 8'h00);
    rd(1'b1, 8'h0f);
    chk("mask", d & 8'h07, 8'h00);
    rd(1'b0, 8'h05);
    chk("unmapped", d, 8'h00);
  endtask : s_reset_vals

  // Timer and external flags set while masked; reads are gated
  task automatic s_flags();
    pulse(0);
    rd(1'b0, 8'h0f);
    chk("masked read", d, 8'h00);
    wr(1'b1, 8'h0e, 8'hc0);
    @(posedge clk);
    port <= 8'h01;
    @(posedge clk);
    port <= 8'h00;
    wr(1'b1, 8'h0f, 8'h05);
    rd(1'b0, 8'h0f);
    chk("timer ext", d, 8'h05);
    wr(1'b0, 8'h0f, 8'h00);
    rd(1'b0, 8'h0f);
    chk("cleared", d, 8'h00);
    wr(1'b1, 8'h0e, 8'h80);
  endtask : s_flags

  task automatic s_port_chg();
    @(posedge clk);
    port <= 8'h02;
    @(posedge clk);
    port <= 8'h00;
    wr(1'b1, 8'h0f, 8'h02);
    rd(1'b0, 8'h0f);
    chk("chg disabled", d, 8'h00);
    wr(1'b1, 8'h0a, 8'hfd);
    port <= 8'h02;
    tick(3);
    rd(1'b0, 8'h0f);
    chk("output pin", d, 8'h00);
    wr(1'b1, 8'h0a, 8'hff);
    tick(2);
    rd(1'b0, 8'h0f);
    chk("input pin", d, 8'h02);
    pulse(2);
    wr(1'b0, 8'h0f, 8'h00);
    rd(1'b0, 8'h0f);
    chk("ref loaded", d, 8'h00);
    @(posedge clk);
    port <= 8'h00;
    pulse(2);
    wr(1'b0, 8'h0f, 8'h00);
    wr(1'b1, 8'h0f, 8'h00);
  endtask : s_port_chg

  task automatic s_vector();
    wr(1'b1, 8'h0f, 8'h01);
    op('{enable_interrupts_instr: 1'b1, default: 1'b0});
    chk("gie eni", gie, 1'b1);
    c = vcnt;
    pulse(0);
    wait_vec(c);
    chk("hw vector", fetch, 11'h008);
    chk("gie taken", gie, 1'b0);
    wr(1'b0, 8'h0f, 8'h00);
    op('{return_from_interrupt_instr: 1'b1, default: 1'b0});
    chk("gie return_from_interrupt_instr", gie, 1'b1);
    op('{disable_interrupts_instr: 1'b1, default: 1'b0});
    chk("gie disable_interrupts_instr", gie, 1'b0);
    c = vcnt;
    op('{swint: 1'b1, default: 1'b0});
    tick(6);
    chk("sw refused", vcnt, c);
    op('{enable_interrupts_instr: 1'b1, default: 1'b0});
    op('{swint: 1'b1, default: 1'b0});
    wait_vec(c);
    chk("sw vector", fetch, 11'h001);
    op('{disable_interrupts_instr: 1'b1, default: 1'b0});
    wr(1'b1, 8'h0f, 8'h00);
  endtask : s_vector

  // Sleep and pin-change wake, global enable off then on
  task automatic s_sleep();
    int n;
    op('{watchdog_clear_instr: 1'b1, default: 1'b0});
    chk("watchdog_clear_instr", {to, pd}, 2'b11);
    for (int g = 0; g < 2; g++) begin
      wr(1'b1, 8'h0e, 8'h00);
      pulse(2);
      wr(1'b1, 8'h0f, 8'h02);
      op(g ? irs_instr_s'{enable_interrupts_instr: 1'b1, default: 1'b0} : irs_instr_s'{disable_interrupts_instr: 1'b1, default: 1'b0});
      c = vcnt;
      op('{sleep: 1'b1, default: 1'b0});
      chk("sleeping", slp, 1'b1);
      chk("wdt clr", wclr, 1'b1);
      chk("sleep tp", {to, pd}, 2'b10);
      @(posedge clk);
      port <= port ^ 8'h04;
      n = 0;
      while (wake !== 1'b1 && n < 10) begin
        tick(1);
        n++;
      end
      chk("wake", wake, 1'b1);
      chk("awake", slp, 1'b0);
      chk("watchdog_enable_bit forced", wen, 1'b1);
      chk("wake tp", {to, pd}, 2'b10);
      tick(4);
      chk("wake vectors", vcnt, c + {7'h00, g[0]});
      pulse(2);
      wr(1'b0, 8'h0f, 8'h00);
      wr(1'b1, 8'h0f, 8'h00);
    end
  endtask : s_sleep

  task automatic s_causes();
    wr(1'b1, 8'h0f, 8'h07);
    wr(1'b1, 8'h0a, 8'h00);
    wr(1'b0, 8'h10, 8'h5a);
    op('{watchdog_clear_instr: 1'b1, default: 1'b0});
    pulse(1);
    chk("wdt rst", crst, 1'b1);
    chk("wdt run tp", {to, pd}, 2'b01);
    tick(2);
    rd(1'b1, 8'h0f);
    chk("mask rst", d & 8'h07, 8'h00);
    chk("ioc_a rst", ioc_a, 8'hff);
    rd(1'b0, 8'h10);
    chk("ram kept", d, 8'h5a);
    @(posedge clk);
    pin_n <= 1'b0;
    tick(3);
    chk("pin held", crst, 1'b1);
    @(posedge clk);
    pin_n <= 1'b1;
    tick(3);
    chk("pin run tp", {to, pd}, 2'b01);
    op('{sleep: 1'b1, default: 1'b0});
    pulse(1);
    chk("wdt slp tp", {to, pd}, 2'b00);
    tick(2);
    chk("wdt wakes", slp, 1'b0);
    op('{sleep: 1'b1, default: 1'b0});
    @(posedge clk);
    pin_n <= 1'b0;
    tick(3);
    @(posedge clk);
    pin_n <= 1'b1;
    tick(3);
    chk("pin slp tp", {to, pd}, 2'b10);
    chk("pin wakes", slp, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk("por tp", {to, pd}, 2'b11);
  endtask : s_causes

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    s_reset_vals();
    s_flags();
    s_port_chg();
    s_vector();
    s_sleep();
    s_causes();
    close_out();
  end
endmodule : irs_top_tb_top
